// file: src/bdmac_pkg.sv
// Package of constants and carriers for the board block-transfer engine
package bdmac_pkg;
  localparam int ADDR_W = 4;
  // Register indices, chosen here; byte address equals index on the plain port
  localparam logic [3:0] REG_IRQ_CTRL_NORMAL = 4'h0;
  localparam logic [3:0] REG_IRQ_CTRL_ERROR  = 4'h1;
  localparam logic [3:0] REG_SRC_ATTR        = 4'h2;
  localparam logic [3:0] REG_DST_ATTR        = 4'h3;
  localparam logic [3:0] REG_GEN_CTRL        = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT_NORMAL = 4'h5;
  localparam logic [3:0] REG_IRQ_STAT_ERROR  = 4'h6;
  localparam logic [3:0] REG_RUN_CTRL        = 4'h7;
  localparam logic [3:0] REG_MODE_STATUS     = 4'h8;
  localparam logic [3:0] REG_SRC_PTR         = 4'h9;
  localparam logic [3:0] REG_DST_PTR         = 4'ha;
  localparam logic [3:0] REG_BYTE_COUNT      = 4'hb;
  // Field positions
  localparam int ATTR_SPACE_LSB = 0;   // attribute bits 1:0 select the bus space
  localparam int RUN_START_BIT  = 0;   // run control: write one to start
  localparam int RUN_ABORT_BIT  = 1;   // run control: write one to abort
  localparam int IRQ_EVENT_BIT  = 0;   // status/mask event bit
  localparam int GEN_IRQ_EN_BIT = 7;   // general control: global interrupt enable
  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  RST_IDX  = 4'h0;
  // Transfer geometry
  localparam int          FIFO_BYTES = 32;
  localparam int          BEAT_BYTES = 4;
  localparam int          BURST_BEATS = FIFO_BYTES / BEAT_BYTES;
  localparam logic [3:0]  BURST_LAST = 4'(BURST_BEATS - 1);

  typedef enum logic [1:0] {SPACE_BACKPLANE, SPACE_EXPANSION, SPACE_SHARED_RAM, SPACE_RSVD} bdmac_space_type;
  typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_READ, ST_RELEASE, ST_WRITE, ST_DONE} bdmac_state_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } bdmac_reg_req_type;

  typedef struct packed {
    logic        req;    // beat request, held until ack
    logic        write;
    logic [1:0]  space;
    logic [31:0] addr;
    logic [3:0]  be;     // byte lanes of this beat
    logic [31:0] wdata;
  } bdmac_mem_req_type;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } bdmac_mem_rsp_type;
endpackage : bdmac_pkg

// file: src/bdmac_top.sv
// Block-transfer engine: register file, staging store and burst sequencer
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps

module bdmac_top (
  input  wire logic                         clk,            // 100 MHz clock
  input  wire logic                         reset_n,        // Sync reset, active low
  input  wire bdmac_pkg::bdmac_reg_req_type reg_req,        // Register port strobes
  output logic [31:0]                       reg_rdata,      // Read data, cycle after strobe
  output bdmac_pkg::bdmac_mem_req_type      mem_req,        // Beat request to bus spaces
  input  wire bdmac_pkg::bdmac_mem_rsp_type mem_rsp,        // Beat answer
  output logic                              local_bus_req,  // Local bus mastership request
  input  wire logic                         local_bus_grant,// Local bus granted, same clock
  output logic                              backplane_hold, // Backplane owned by engine
  input  wire logic                         cpu_bp_req,     // CPU wants the backplane
  output logic                              cpu_bp_grant,   // CPU may go to backplane
  output logic                              irq             // Level interrupt
);
  localparam int BURST_W = bdmac_pkg::BURST_BEATS;
  typedef struct packed {
    logic [7:0]  ictl_n, ictl_e, sattr, dattr, gctl, ist_n, ist_e, run;
    logic [31:0] src, dst, cnt;
    bdmac_pkg::bdmac_state_type st;
    logic [3:0]  beat;
    logic [3:0]  fill;
    logic [5:0]  bytes;                 // bytes held in the current burst
    logic        cpu_grant;
    logic [31:0] rdata;
    bdmac_pkg::bdmac_mem_req_type mr;
    logic [BURST_W-1:0][31:0] store;
  } state_type;

  state_type s_r, s_nxt;

  // Lanes from address up to the word end, limited by what remains
  function automatic logic [2:0] chunk(input logic [1:0] a, input logic [31:0] left);
    logic [2:0] room;
    room = 3'(bdmac_pkg::BEAT_BYTES) - {1'b0, a};
    chunk = (left < 32'(room)) ? left[2:0] : room;
  endfunction : chunk

  function automatic logic [3:0] lanes(input logic [1:0] a, input logic [2:0] n);
    lanes = 4'(((5'h01 << n) - 5'h01) << a);
  endfunction : lanes

  logic [2:0]  rn, wn;
  always_comb begin
    s_nxt = s_r;
    rn = chunk(s_r.src[1:0], s_r.cnt);
    wn = chunk(s_r.dst[1:0], 32'(s_r.bytes));
    s_nxt.rdata = 32'h0000_0000;
    // Register reads
    if (reg_req.rd) begin
      case (reg_req.addr)
        bdmac_pkg::REG_IRQ_CTRL_NORMAL: s_nxt.rdata = {24'h000000, s_r.ictl_n};
        bdmac_pkg::REG_IRQ_CTRL_ERROR:  s_nxt.rdata = {24'h000000, s_r.ictl_e};
        bdmac_pkg::REG_SRC_ATTR:        s_nxt.rdata = {24'h000000, s_r.sattr};
        bdmac_pkg::REG_DST_ATTR:        s_nxt.rdata = {24'h000000, s_r.dattr};
        bdmac_pkg::REG_GEN_CTRL:        s_nxt.rdata = {24'h000000, s_r.gctl};
        bdmac_pkg::REG_IRQ_STAT_NORMAL: s_nxt.rdata = {24'h000000, s_r.ist_n};
        bdmac_pkg::REG_IRQ_STAT_ERROR:  s_nxt.rdata = {24'h000000, s_r.ist_e};
        bdmac_pkg::REG_RUN_CTRL:        s_nxt.rdata = {24'h000000, s_r.run};
        bdmac_pkg::REG_MODE_STATUS:     s_nxt.rdata = {24'h000000, 1'b0, s_r.st, s_r.fill};
        bdmac_pkg::REG_SRC_PTR:         s_nxt.rdata = s_r.src;
        bdmac_pkg::REG_DST_PTR:         s_nxt.rdata = s_r.dst;
        bdmac_pkg::REG_BYTE_COUNT:      s_nxt.rdata = s_r.cnt;
        default:                        s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes; pointers and count are locked while running
    if (reg_req.wr) begin
      case (reg_req.addr)
        bdmac_pkg::REG_IRQ_CTRL_NORMAL: s_nxt.ictl_n = reg_req.wdata[7:0];
        bdmac_pkg::REG_IRQ_CTRL_ERROR:  s_nxt.ictl_e = reg_req.wdata[7:0];
        bdmac_pkg::REG_SRC_ATTR:        s_nxt.sattr = reg_req.wdata[7:0];
        bdmac_pkg::REG_DST_ATTR:        s_nxt.dattr = reg_req.wdata[7:0];
        bdmac_pkg::REG_GEN_CTRL:        s_nxt.gctl = reg_req.wdata[7:0];
        bdmac_pkg::REG_IRQ_STAT_NORMAL: s_nxt.ist_n = s_r.ist_n & ~reg_req.wdata[7:0];
        bdmac_pkg::REG_IRQ_STAT_ERROR:  s_nxt.ist_e = s_r.ist_e & ~reg_req.wdata[7:0];
        bdmac_pkg::REG_RUN_CTRL:        s_nxt.run = reg_req.wdata[7:0];
        bdmac_pkg::REG_SRC_PTR:         if (s_r.st == bdmac_pkg::ST_IDLE) s_nxt.src = reg_req.wdata;
        bdmac_pkg::REG_DST_PTR:         if (s_r.st == bdmac_pkg::ST_IDLE) s_nxt.dst = reg_req.wdata;
        bdmac_pkg::REG_BYTE_COUNT:      if (s_r.st == bdmac_pkg::ST_IDLE) s_nxt.cnt = reg_req.wdata;
        default: ;
      endcase
    end
    // Start and abort are self-clearing commands
    s_nxt.run[bdmac_pkg::RUN_START_BIT] = 1'b0;
    s_nxt.run[bdmac_pkg::RUN_ABORT_BIT] = 1'b0;
    // Sequencer
    case (s_r.st)
      bdmac_pkg::ST_IDLE: begin
        s_nxt.mr.req = 1'b0;
        if (reg_req.wr && reg_req.addr == bdmac_pkg::REG_RUN_CTRL
            && reg_req.wdata[bdmac_pkg::RUN_START_BIT]) begin
          if (s_nxt.cnt == 32'h0000_0000) begin
            s_nxt.st = bdmac_pkg::ST_DONE;
            s_nxt.ist_n[bdmac_pkg::IRQ_EVENT_BIT] = 1'b1;
          end else begin
            s_nxt.st = bdmac_pkg::ST_ARB;
          end
        end
      end
      bdmac_pkg::ST_ARB: begin
        // Shared RAM side needs the local bus first
        if (local_bus_grant || s_r.sattr[1:0] != 2'(bdmac_pkg::SPACE_SHARED_RAM)) begin
          s_nxt.st = bdmac_pkg::ST_READ;
          s_nxt.beat = bdmac_pkg::RST_IDX;
          s_nxt.fill = bdmac_pkg::RST_IDX;
          s_nxt.bytes = 6'h00;
          s_nxt.mr = '{req: 1'b1, write: 1'b0, space: s_r.sattr[1:0], addr: {s_r.src[31:2], 2'b00},
                       be: lanes(s_r.src[1:0], rn), wdata: 32'h0000_0000};
        end
      end
      bdmac_pkg::ST_READ: begin
        if (mem_rsp.ack) begin
          s_nxt.store[s_r.beat] = mem_rsp.rdata;
          s_nxt.fill = s_r.fill + 4'h1;
          s_nxt.src = s_r.src + 32'(rn);
          s_nxt.cnt = s_r.cnt - 32'(rn);
          s_nxt.bytes = s_r.bytes + 6'(rn);
          // Gather stops at eight beats or end of count
          if (mem_rsp.err) begin
            s_nxt.st = bdmac_pkg::ST_DONE;
            s_nxt.mr.req = 1'b0;
            s_nxt.ist_e[bdmac_pkg::IRQ_EVENT_BIT] = 1'b1;
          end else if (s_r.beat == bdmac_pkg::BURST_LAST || s_r.cnt == 32'(rn)) begin
            s_nxt.st = bdmac_pkg::ST_RELEASE;
            s_nxt.mr.req = 1'b0;
          end else begin
            s_nxt.beat = s_r.beat + 4'h1;
            s_nxt.mr.addr = {s_nxt.src[31:2], 2'b00};
            s_nxt.mr.be = lanes(s_nxt.src[1:0], chunk(s_nxt.src[1:0], s_nxt.cnt));
          end
        end
      end
      bdmac_pkg::ST_RELEASE: begin
        // Backplane given up before shared RAM writes; wait for local grant
        if (local_bus_grant || s_r.dattr[1:0] != 2'(bdmac_pkg::SPACE_SHARED_RAM)) begin
          s_nxt.st = bdmac_pkg::ST_WRITE;
          s_nxt.beat = bdmac_pkg::RST_IDX;
          s_nxt.mr = '{req: 1'b1, write: 1'b1, space: s_r.dattr[1:0], addr: {s_r.dst[31:2], 2'b00},
                       be: lanes(s_r.dst[1:0], wn), wdata: s_r.store[0]};
        end
      end
      bdmac_pkg::ST_WRITE: begin
        if (mem_rsp.ack) begin
          s_nxt.dst = s_r.dst + 32'(wn);
          s_nxt.bytes = s_r.bytes - 6'(wn);
          s_nxt.fill = s_r.fill - 4'h1;
          if (mem_rsp.err) begin
            s_nxt.st = bdmac_pkg::ST_DONE;
            s_nxt.mr.req = 1'b0;
            s_nxt.ist_e[bdmac_pkg::IRQ_EVENT_BIT] = 1'b1;
          end else if (s_r.bytes == 6'(wn)) begin
            s_nxt.mr.req = 1'b0;
            s_nxt.fill = bdmac_pkg::RST_IDX;
            s_nxt.st = (s_r.cnt == 32'h0000_0000) ? bdmac_pkg::ST_DONE : bdmac_pkg::ST_ARB;
            if (s_r.cnt == 32'h0000_0000) s_nxt.ist_n[bdmac_pkg::IRQ_EVENT_BIT] = 1'b1;
          end else begin
            // Simplification: store words are replayed in order, lanes shifted to destination
            s_nxt.beat = s_r.beat + 4'h1;
            s_nxt.mr.addr = {s_nxt.dst[31:2], 2'b00};
            s_nxt.mr.be = lanes(s_nxt.dst[1:0], chunk(s_nxt.dst[1:0], 32'(s_nxt.bytes)));
            s_nxt.mr.wdata = s_r.store[s_r.beat + 4'h1];
          end
        end
      end
      bdmac_pkg::ST_DONE: begin
        // Normal end flagged by its cause, so a failed last beat never reports done
        s_nxt.mr.req = 1'b0;
        s_nxt.st = bdmac_pkg::ST_IDLE;
      end
      default: s_nxt.st = bdmac_pkg::ST_IDLE;
    endcase
    // Abort ends the transfer as an error
    if (reg_req.wr && reg_req.addr == bdmac_pkg::REG_RUN_CTRL && reg_req.wdata[bdmac_pkg::RUN_ABORT_BIT]
        && s_r.st != bdmac_pkg::ST_IDLE) begin
      s_nxt.st = bdmac_pkg::ST_IDLE;
      s_nxt.mr.req = 1'b0;
      s_nxt.ist_e[bdmac_pkg::IRQ_EVENT_BIT] = 1'b1;
    end
    // CPU reaches backplane only when idle, arbitrating or done, never mid-burst
    s_nxt.cpu_grant = cpu_bp_req && (s_nxt.st == bdmac_pkg::ST_IDLE || s_nxt.st == bdmac_pkg::ST_ARB
                                     || s_nxt.st == bdmac_pkg::ST_DONE);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign mem_req = s_r.mr;
  // Local bus asked only when a shared RAM side is active; CPU otherwise untouched
  assign local_bus_req = (s_r.st == bdmac_pkg::ST_ARB && s_r.sattr[1:0] == 2'(bdmac_pkg::SPACE_SHARED_RAM))
                      || (s_r.st == bdmac_pkg::ST_RELEASE && s_r.dattr[1:0] == 2'(bdmac_pkg::SPACE_SHARED_RAM))
                      || (s_r.mr.req && s_r.mr.space == 2'(bdmac_pkg::SPACE_SHARED_RAM));
  assign backplane_hold = s_r.mr.req && s_r.mr.space == 2'(bdmac_pkg::SPACE_BACKPLANE);
  assign cpu_bp_grant = s_r.cpu_grant;
  assign irq = s_r.gctl[bdmac_pkg::GEN_IRQ_EN_BIT]
             && (|(s_r.ist_n & s_r.ictl_n) || |(s_r.ist_e & s_r.ictl_e));
endmodule : bdmac_top

// file: sim/bdmac_checker.sv
// Port assertions of the block-transfer engine
`timescale 1ns/1ps
module bdmac_checker (
  input wire logic                         clk,             // Clock
  input wire logic                         reset_n,         // Sync reset
  input wire bdmac_pkg::bdmac_reg_req_type reg_req,         // Register strobes
  input wire logic [31:0]                  reg_rdata,       // Read data
  input wire bdmac_pkg::bdmac_mem_req_type mem_req,         // Beat request
  input wire bdmac_pkg::bdmac_mem_rsp_type mem_rsp,         // Beat answer
  input wire logic                         local_bus_req,   // Local bus request
  input wire logic                         local_bus_grant, // Local bus grant
  input wire logic                         backplane_hold,  // Backplane owned
  input wire logic                         cpu_bp_req,      // CPU backplane request
  input wire logic                         cpu_bp_grant,    // CPU backplane grant
  input wire logic                         irq              // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence beat_wait_s; mem_req.req && !mem_rsp.ack; endsequence
  sequence shared_beat_s; mem_req.req && mem_req.space == 2'h2; endsequence
  sequence beat_fail_s; mem_req.req && mem_rsp.ack && mem_rsp.err; endsequence
  logic [4:0] rd_cnt_r;
  // Read acks since the last write beat; an error clears the count
  always_ff @(posedge clk) begin
    if (!reset_n || (mem_req.req && mem_req.write) || mem_rsp.err) rd_cnt_r <= 5'h00;
    else if (mem_req.req && mem_rsp.ack) rd_cnt_r <= rd_cnt_r + 5'h01;
  end
  chk_beat_held: assert property (beat_wait_s |=> mem_req.req && $stable(mem_req))
    else $error("beat request changed before ack");
  chk_word_beats: assert property (mem_req.req |-> mem_req.addr[1:0] == 2'h0)
    else $error("beat address not word aligned");
  chk_shared_grant: assert property (shared_beat_s |-> local_bus_req && local_bus_grant)
    else $error("shared RAM beat without local bus grant");
  chk_bp_released: assert property ((shared_beat_s and $rose(mem_req.write)) |-> !$past(backplane_hold))
    else $error("backplane held during shared RAM write");
  chk_cpu_wait: assert property (cpu_bp_grant |-> !backplane_hold)
    else $error("CPU granted while engine holds backplane");
  chk_cpu_bound: assert property ($rose(cpu_bp_req) |-> ##[1:300] (cpu_bp_grant || !cpu_bp_req))
    else $error("CPU backplane request never granted");
  chk_burst_len: assert property (mem_req.req && !mem_req.write |-> rd_cnt_r < 5'h08)
    else $error("more than eight reads in a burst");
  chk_err_stop: assert property (beat_fail_s |=> !mem_req.req [*3])
    else $error("transfer went on after bus error");
endmodule : bdmac_checker

// file: sim/bdmac_bus_model.sv
// Far-side buses and local arbiter seen by the engine
`timescale 1ns/1ps
module bdmac_bus_model (
  input  wire logic                         clk,             // Clock
  input  wire logic                         reset_n,         // Sync reset
  input  wire logic                         slow,            // Two wait cycles per beat
  input  wire logic [31:0]                  err_addr,        // Beat answered with error
  input  wire bdmac_pkg::bdmac_mem_req_type mem_req,         // Beat request
  output bdmac_pkg::bdmac_mem_rsp_type      mem_rsp,         // Beat answer
  input  wire logic                         local_bus_req,   // Mastership request
  output logic                              local_bus_grant  // Mastership grant
);
  logic [1:0] wait_r;
  always_ff @(posedge clk) begin
    // Grant a cycle late so the engine must wait for it
    local_bus_grant <= local_bus_req && reset_n;
    if (!reset_n) begin
      mem_rsp <= '0;
      wait_r <= 2'h0;
    end else if (mem_req.req && !mem_rsp.ack && (wait_r == 2'h2 || !slow)) begin
      mem_rsp <= '{1'b1, mem_req.addr == err_addr, {~mem_req.addr[15:0], mem_req.addr[15:0]}};
      wait_r <= 2'h0;
    end else begin
      // Data lines toggle between answers, never a stale word
      mem_rsp <= '{1'b0, 1'b0, ~mem_rsp.rdata};
      wait_r <= (mem_req.req && !mem_rsp.ack) ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule : bdmac_bus_model

// file: sim/tb_board_dma_controller.sv
// Self-checking bench of the block-transfer engine
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_board_dma_controller;
  logic                         clk, reset_n, lb_req, lb_grant, bp_hold, cpu_bp_req, cpu_bp_grant, irq, slow, data_chk;
  logic [31:0]                  reg_rdata, err_addr, seed, exp_src, exp_dst, rd, exp_w;
  logic [1:0]                   src_sp, dst_sp;
  bdmac_pkg::bdmac_reg_req_type reg_req;
  bdmac_pkg::bdmac_mem_req_type mem_req;
  bdmac_pkg::bdmac_mem_rsp_type mem_rsp;
  int                           mismatches, tests_run;
  logic [31:0]                  fifo_q[$];
  bdmac_top uut (.clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .local_bus_req(lb_req), .local_bus_grant(lb_grant), .backplane_hold(bp_hold),
    .cpu_bp_req(cpu_bp_req), .cpu_bp_grant(cpu_bp_grant), .irq(irq));
  bdmac_bus_model model (.clk(clk), .reset_n(reset_n), .slow(slow), .err_addr(err_addr), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .local_bus_req(lb_req), .local_bus_grant(lb_grant));
  initial begin clk = 1'b0; forever #5 clk = ~clk; end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    reg_req <= '0;
  endtask : wr
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    reg_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk);
    reg_req <= '0;
    @(negedge clk);
    rd = reg_rdata;
  endtask : rd_reg
  // Expected words follow the source order through the staging store
  always @(posedge clk) if (reset_n && mem_req.req && mem_rsp.ack && !mem_rsp.err) begin
    if (!data_chk && !mem_req.write && mem_req.addr == 32'h0) `CHK("lanes", 4'hc, mem_req.be)
    if (data_chk && !mem_req.write) begin
      `CHK("src", {exp_src, src_sp}, {mem_req.addr, mem_req.space})
      `CHK("fill", 1'b1, fifo_q.size() < 8)
      fifo_q.push_back({~exp_src[15:0], exp_src[15:0]});
      exp_src += 32'h4;
    end else if (data_chk) begin
      `CHK("dst", {exp_dst, dst_sp}, {mem_req.addr, mem_req.space})
      // Popped once here; the compare macro evaluates its expected value twice
      exp_w = fifo_q.pop_front();
      `CHK("wdata", exp_w, mem_req.wdata)
      exp_dst += 32'h4;
    end
  end
  task automatic xfer(input logic [1:0] ss, ds, input logic [31:0] sa, da, n, input logic bad);
    fifo_q.delete();
    {exp_src, exp_dst, src_sp, dst_sp, data_chk} = {sa, da, ss, ds, sa[1:0] == 2'h0};
    wr(4'h2, 32'(ss));
    wr(4'h3, 32'(ds));
    wr(4'h9, sa);
    wr(4'ha, da);
    wr(4'hb, n);
    wr(4'h7, 32'h1);
    repeat (4) @(posedge clk);
    cpu_bp_req <= 1'b1;
    for (int i = 0; i < 900 && (irq !== 1'b1 || cpu_bp_req); i++) begin
      @(posedge clk);
      if (cpu_bp_grant === 1'b1) cpu_bp_req <= 1'b0;
    end
    `CHK("irq", 2'b10, {irq, cpu_bp_req})
    rd_reg(bad ? 4'h6 : 4'h5);
    `CHK("end", 32'h1, rd)
    if (!bad) begin
      rd_reg(4'hb);
      `CHK("count", 32'h0, rd)
      rd_reg(4'h9);
      `CHK("srcptr", sa + n, rd)
      wr(4'h5, 32'h1);
      rd_reg(4'h5);
      `CHK("clear", 33'h0, {irq, rd})
    end
  endtask : xfer
  initial begin
    {reset_n, cpu_bp_req, slow, data_chk} = 4'h0;
    reg_req = '0;
    err_addr = 32'hffffffff;
    seed = 32'hf8a5;
    mismatches = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 13; a++) begin
      rd_reg(a[3:0]);
      `CHK("reset", 32'h0, rd)
    end
    for (int a = 0; a < 12; a++) begin
      seed = lfsr(seed);
      wr(a[3:0], a == 7 ? 32'h0 : seed);
      rd_reg(a[3:0]);
      `CHK("reg", a inside {[5:8]} ? 32'h0 : a > 8 ? seed : {24'h0, seed[7:0]}, rd)
    end
    wr(4'h0, 32'h1);
    wr(4'h1, 32'h1);
    wr(4'h4, 32'h80);
    for (int k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      slow <= seed[0];
      xfer(2'(k / 3), 2'(k % 3), seed & 32'hfffc, {16'h1, seed[15:8], 8'h0}, k % 4 == 0 ? 48 : 32, 1'b0);
    end
    xfer(2'h1, 2'h0, 32'h100, 32'h500, 32'h0, 1'b0);
    xfer(2'h2, 2'h2, 32'h2, 32'h3000, 32'h6, 1'b0);
    err_addr <= 32'h204;
    xfer(2'h0, 2'h1, 32'h200, 32'h400, 32'h20, 1'b1);
    wr(4'h1, 32'h0);
    rd_reg(4'h6);
    `CHK("masked", 33'h1, {irq, rd})
    stop_test();
  end
  initial begin
    #300000;
    mismatches++;
    stop_test();
  end
endmodule : tb_board_dma_controller
bind bdmac_top bdmac_checker chk (.clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .mem_req(mem_req), .mem_rsp(mem_rsp), .local_bus_req(local_bus_req), .local_bus_grant(local_bus_grant),
  .backplane_hold(backplane_hold), .cpu_bp_req(cpu_bp_req), .cpu_bp_grant(cpu_bp_grant), .irq(irq));
